// file: rtl/analog_io_pkg.sv
// Constants, register map and field layout of the analog I/O sampling controller.
package analog_io_pkg;
  localparam int NUM_CH = 2;
  localparam int CODE_W = 12;
  localparam int VAL_W = 16;
  localparam int DEPTH_W = 7;
  localparam int RAM_AW = 7;
  localparam int SUM_W = 20;
  // Scan tick: 2 ms at 40 MHz.
  localparam int CLK_FREQ_KHZ = 40000;
  localparam int TICK_TIME_US = 2000;
  localparam int TICK_CYCLES_DEF = CLK_FREQ_KHZ * TICK_TIME_US / 1000;
  localparam int TICK_CNT_W = 17;
  localparam logic [4:0] DIV_STEPS = 5'h14;
  // Register byte addresses.
  localparam logic [7:0] REG_AIN_CH1 = 8'h00;
  localparam logic [7:0] REG_AIN_CH2 = 8'h04;
  localparam logic [7:0] REG_VALID = 8'h08;
  localparam logic [7:0] REG_AOUT_CH1 = 8'h0C;
  localparam logic [7:0] REG_AOUT_CH2 = 8'h10;
  localparam logic [7:0] REG_CONFIG = 8'h14;
  localparam logic [7:0] REG_BOARD_TEMP = 8'h18;
  // Configuration register fields.
  localparam int CFG_DEPTH_LSB = 0;
  localparam int CFG_TC_DEPTH_LSB = 8;
  localparam int CFG_TC_MODE_BIT = 16;
  localparam int CFG_RANGE_LSB = 17;
  localparam int CFG_HOLD_LSB = 19;
  localparam logic [6:0] MAX_DEPTH = 7'h40;
  localparam logic [6:0] TC_STAGE1_COUNT = 7'h15;
  localparam logic [11:0] CURRENT_OFFSET = 12'h320;
  localparam logic [11:0] CODE_MAX = 12'hFFF;
  localparam logic [15:0] TC_SENTINEL_POS = 16'h7FFF;
  localparam logic [15:0] TC_SENTINEL_NEG = 16'h8000;
  localparam logic [15:0] CURRENT_VALUE_MIN = 16'hFC18;
  // Thermocouple codes beyond which the input counts as out of range.
  localparam logic [11:0] TC_HI_CODE = 12'hFF0;
  localparam logic [11:0] TC_LO_CODE = 12'h010;
  localparam logic [1:0] LAST_CH_SLOT = 2'h1;
  localparam logic [1:0] BOARD_SLOT = 2'h2;
endpackage

// file: rtl/sample_ram.sv
// Sample history memory of the input averaging window, with registered read data.
`timescale 1ns/1ps
module sample_ram (
  input  wire logic                                 clk,
  input  wire logic                                 we,
  input  wire logic [analog_io_pkg::RAM_AW-1:0]     waddr,
  input  wire logic [analog_io_pkg::CODE_W-1:0]     wdata,
  input  wire logic [analog_io_pkg::RAM_AW-1:0]     raddr,
  output logic      [analog_io_pkg::CODE_W-1:0]     rdata
);
  import analog_io_pkg::*;

  logic [CODE_W-1:0] mem [2**RAM_AW];

  // Write port and registered read port; a read of the written word returns the old one.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// file: rtl/analog_io_ctrl.sv
// Analog input scanning, averaging filters and analog output refresh controller.
// Operation
// - One input channel is sampled per 2 ms tick as a 12-bit code.
// - Each tick the newest sample is averaged with earlier ones up to depth.
// - Depth accepts 0 to 64; zero passes samples through unchanged.
// - Until depth samples are collected, valid is low and value reads zero.
// - One filter depth applies to all input channels.
// - Input codes 0 to 4095 cover the full voltage or current range.
// - In 4-20 mA range value is (raw-800)*1.25 rounded, down to -1000.
// - Valid word: bit 0 channel 1, bit 1 channel 2, 1 means valid.
// - Every 2 ms output values are read and driven to output terminals.
// - With hold enabled, a stopped program keeps the output at last value.
// - Offline or reset clears outputs and every retained output value.
// - Output codes 0 to 4095 span the full output range.
// - Thermocouple mode samples each channel, then board temperature, one per tick.
// - Twenty-one first-stage samples are averaged into a second-stage entry.
// - When second-stage count reaches the setting, entries are averaged again.
// - Thermocouple filter setting and range are shared by all channels.
// - Temperature becomes valid only after ticks*(channels+1)*21*setting.
// - Out of range input discards samples and reports 32767 or -32768.
// - Thermocouple setting zero disables the second averaging stage.
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module analog_io_ctrl #(
  parameter int unsigned TICK_CYCLES = analog_io_pkg::TICK_CYCLES_DEF
) (
  input  wire logic                              clk,
  input  wire logic                              sys_rst,
  input  wire logic [7:0]                        reg_addr,
  input  wire logic [31:0]                       reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic      [31:0]                       reg_rdata,
  input  wire logic                              prog_run,
  input  wire logic                              offline,
  output logic                                   adc_start,
  output logic      [1:0]                        adc_sel,
  input  wire logic                              adc_done,
  input  wire logic [analog_io_pkg::CODE_W-1:0]  adc_code,
  output logic                                   dac_load,
  output logic      [analog_io_pkg::CODE_W-1:0]  dac_code_ch1,
  output logic      [analog_io_pkg::CODE_W-1:0]  dac_code_ch2
);
  import analog_io_pkg::*;

  typedef enum {ST_IDLE, ST_CONV, ST_ACC, ST_DIV, ST_DONE} scan_state_e;
  typedef enum {DS_WIN, DS_TC1, DS_TC2} div_stage_e;

  scan_state_e       state;
  div_stage_e        stage;
  logic [TICK_CNT_W-1:0] tick_cnt;
  logic              tick;
  logic [1:0]        slot;
  logic [CODE_W-1:0] sample;
  logic [CODE_W-1:0] board_temp;
  logic [DEPTH_W-1:0] filt_depth;
  logic [DEPTH_W-1:0] tc_depth;
  logic              tc_mode;
  logic [NUM_CH-1:0] range_420;
  logic [NUM_CH-1:0] hold_en;
  logic [CODE_W-1:0] aout [NUM_CH];
  logic [VAL_W-1:0]  ain [NUM_CH];
  logic [NUM_CH-1:0] valid;
  logic [SUM_W-1:0]  win_sum [NUM_CH];
  logic [DEPTH_W-1:0] win_cnt [NUM_CH];
  logic [5:0]        win_ptr [NUM_CH];
  logic [SUM_W-1:0]  s1_sum [NUM_CH];
  logic [DEPTH_W-1:0] s1_cnt [NUM_CH];
  logic [SUM_W-1:0]  s2_sum [NUM_CH];
  logic [DEPTH_W-1:0] s2_cnt [NUM_CH];
  logic              pub_en;
  logic              pub_valid;
  logic              pub_sent;
  logic              pub_neg;
  logic [7:0]        div_rem;
  logic [SUM_W-1:0]  div_quo;
  logic [DEPTH_W-1:0] div_den;
  logic [4:0]        div_cnt;
  logic [CODE_W-1:0] ram_rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Decodes and datapath terms.

  // Register strobes and configuration fields, depths clamped to 64.
  wire              cfg_wr      = reg_wr && (reg_addr == REG_CONFIG);
  wire [DEPTH_W-1:0] wr_depth_raw = reg_wdata[CFG_DEPTH_LSB +: DEPTH_W];
  wire [DEPTH_W-1:0] wr_tc_raw   = reg_wdata[CFG_TC_DEPTH_LSB +: DEPTH_W];
  wire [DEPTH_W-1:0] wr_depth    = (wr_depth_raw > MAX_DEPTH) ? MAX_DEPTH : wr_depth_raw;
  wire [DEPTH_W-1:0] wr_tc_depth = (wr_tc_raw > MAX_DEPTH) ? MAX_DEPTH : wr_tc_raw;
  wire              clear_all   = cfg_wr && ((wr_depth != filt_depth) ||
                                  (wr_tc_depth != tc_depth) ||
                                  (reg_wdata[CFG_TC_MODE_BIT] != tc_mode));
  wire              ch          = slot[0];
  wire [1:0]        last_slot   = tc_mode ? BOARD_SLOT : LAST_CH_SLOT;

  // Running window: the oldest sample leaves once the window is full.
  wire              win_full  = win_cnt[ch] == filt_depth;
  wire [DEPTH_W-1:0] win_cnt_inc = DEPTH_W'(win_cnt[ch] + 7'h01);
  wire [SUM_W-1:0]  win_old   = win_full ? {8'h00, ram_rdata} : '0;
  wire [SUM_W-1:0]  win_next  = SUM_W'(win_sum[ch] + {8'h00, sample} - win_old);
  wire [DEPTH_W-1:0] ptr_inc  = DEPTH_W'({1'b0, win_ptr[ch]} + 7'h01);
  wire [5:0]        ptr_next  = (ptr_inc == filt_depth) ? 6'h00 : ptr_inc[5:0];
  wire              ram_we    = (state == ST_ACC) && !tc_mode && (filt_depth != '0);
  wire [RAM_AW-1:0] ram_addr  = {ch, win_ptr[ch]};

  // Thermocouple limits and stage sums.
  wire              tc_hi     = sample > TC_HI_CODE;
  wire              tc_lo     = sample < TC_LO_CODE;
  wire [SUM_W-1:0]  s1_next   = SUM_W'(s1_sum[ch] + {8'h00, sample});
  wire [SUM_W-1:0]  s2_next   = SUM_W'(s2_sum[ch] + div_quo);

  // Restoring divider step.
  wire [7:0]        div_shift = {div_rem[6:0], div_quo[SUM_W-1]};
  wire              div_fit   = div_shift >= {1'b0, div_den};

  // Current range scaling with rounding, clamped to the 12-bit top.
  wire signed [15:0] cur_x     = $signed({4'h0, div_quo[CODE_W-1:0]}) -
                                 $signed({4'h0, CURRENT_OFFSET});
  wire signed [15:0] cur_sc    = (cur_x + (cur_x <<< 2) + 16'sh0002) >>> 2;
  wire [15:0]       cur_word  = (cur_sc > $signed({4'h0, CODE_MAX})) ? {4'h0, CODE_MAX} :
                                cur_sc;
  wire [15:0]       code_word = {4'h0, div_quo[CODE_W-1:0]};
  wire [15:0]       ana_word  = !pub_valid ? 16'h0000 : (range_420[ch] ? cur_word : code_word);
  wire [15:0]       tc_word   = pub_sent ? (pub_neg ? TC_SENTINEL_NEG : TC_SENTINEL_POS) :
                                code_word;
  wire [15:0]       pub_word  = tc_mode ? tc_word : ana_word;

  ////////////////////////////////////////////////////////////////////////////////
  // Sample history memory.

  sample_ram u_ram (
    .clk   (clk),
    .we    (ram_we),
    .waddr (ram_addr),
    .wdata (sample),
    .raddr (ram_addr),
    .rdata (ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // 2 ms tick divider.

  // One-cycle tick every TICK_CYCLES clocks.
  always_ff @(posedge clk) begin
    if (sys_rst || tick_cnt == TICK_CNT_W'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
    tick <= !sys_rst && (tick_cnt == TICK_CNT_W'(TICK_CYCLES - 1));
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register file.

  // Configuration and output data; going offline drops every retained output value.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      filt_depth <= '0;
      tc_depth   <= '0;
      tc_mode    <= 1'b0;
      range_420  <= '0;
      hold_en    <= '0;
      aout       <= '{default: '0};
    end else begin
      if (cfg_wr) begin
        filt_depth <= wr_depth;
        tc_depth   <= wr_tc_depth;
        tc_mode    <= reg_wdata[CFG_TC_MODE_BIT];
        range_420  <= reg_wdata[CFG_RANGE_LSB +: NUM_CH];
        hold_en    <= reg_wdata[CFG_HOLD_LSB +: NUM_CH];
      end
      if (offline) begin
        aout <= '{default: '0};
      end else if (reg_wr && reg_addr == REG_AOUT_CH1) begin
        aout[0] <= reg_wdata[CODE_W-1:0];
      end else if (reg_wr && reg_addr == REG_AOUT_CH2) begin
        aout[1] <= reg_wdata[CODE_W-1:0];
      end
    end
  end

  // Read data stands in the cycle after the read strobe only.
  always_ff @(posedge clk) begin
    if (sys_rst || !reg_rd) begin
      reg_rdata <= '0;
    end else begin
      case (reg_addr)
        REG_AIN_CH1:    reg_rdata <= {16'h0000, ain[0]};
        REG_AIN_CH2:    reg_rdata <= {16'h0000, ain[1]};
        REG_VALID:      reg_rdata <= {30'h0, valid};
        REG_AOUT_CH1:   reg_rdata <= {20'h0, aout[0]};
        REG_AOUT_CH2:   reg_rdata <= {20'h0, aout[1]};
        REG_CONFIG:     reg_rdata <= {11'h0, hold_en, range_420, tc_mode, 1'b0, tc_depth,
                                      1'b0, filt_depth};
        REG_BOARD_TEMP: reg_rdata <= {20'h0, board_temp};
        default:        reg_rdata <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Analog output refresh.

  // Each tick the outputs follow the host data, are held, or fall to zero.
  always_ff @(posedge clk) begin
    if (sys_rst || offline) begin
      dac_load     <= 1'b0;
      dac_code_ch1 <= '0;
      dac_code_ch2 <= '0;
    end else begin
      dac_load <= tick;
      if (tick && (prog_run || !hold_en[0])) begin
        dac_code_ch1 <= prog_run ? aout[0] : '0;
      end
      if (tick && (prog_run || !hold_en[1])) begin
        dac_code_ch2 <= prog_run ? aout[1] : '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Scan, filter and publish sequencer.

  // One slot converted per tick, then filtered and published.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      stage <= DS_WIN;
      slot <= '0;
      adc_start <= 1'b0;
      adc_sel <= '0;
      sample <= '0;
      board_temp <= '0;
      {pub_en, pub_valid, pub_sent, pub_neg} <= '0;
      {div_rem, div_quo, div_den, div_cnt} <= '0;
    end else begin
      adc_start <= 1'b0;
      pub_en <= 1'b0;
      case (state)
        ST_IDLE: begin
          pub_sent <= 1'b0;
          if (tick) begin
            adc_start <= 1'b1;
            adc_sel <= slot;
            state <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (adc_done) begin
            sample <= adc_code;
            if (slot == BOARD_SLOT) begin
              board_temp <= adc_code;
              state <= ST_DONE;
            end else begin
              state <= ST_ACC;
            end
          end
        end
        ST_ACC: begin
          state <= ST_DONE;
          if (!tc_mode && filt_depth == '0) begin
            div_quo <= {8'h00, sample};
            pub_valid <= 1'b1;
            pub_en <= 1'b1;
          end else if (!tc_mode) begin
            if (win_full || win_cnt_inc == filt_depth) begin
              {div_rem, div_quo, div_den, div_cnt} <= {8'h00, win_next, filt_depth, DIV_STEPS};
              stage <= DS_WIN;
              state <= ST_DIV;
            end else begin
              pub_valid <= 1'b0;
              pub_en <= 1'b1;
            end
          end else if (tc_hi || tc_lo) begin
            pub_sent <= 1'b1;
            pub_neg <= tc_lo;
            pub_valid <= 1'b0;
            pub_en <= 1'b1;
          end else if (s1_cnt[ch] == TC_STAGE1_COUNT - 7'h01) begin
            {div_rem, div_quo, div_den, div_cnt} <= {8'h00, s1_next, TC_STAGE1_COUNT,
                                                     DIV_STEPS};
            stage <= DS_TC1;
            state <= ST_DIV;
          end
        end
        ST_DIV: begin
          if (div_cnt != '0) begin
            div_rem <= div_fit ? 8'(div_shift - {1'b0, div_den}) : div_shift;
            div_quo <= {div_quo[SUM_W-2:0], div_fit};
            div_cnt <= div_cnt - 5'h01;
          end else begin
            state <= ST_DONE;
            if (stage != DS_TC1 || tc_depth == '0) begin
              pub_valid <= 1'b1;
              pub_en <= 1'b1;
            end else if (s2_cnt[ch] == tc_depth - 7'h01) begin
              {div_rem, div_quo, div_den, div_cnt} <= {8'h00, s2_next, tc_depth,
                                                       DIV_STEPS};
              stage <= DS_TC2;
              state <= ST_DIV;
            end
          end
        end
        ST_DONE: begin
          slot <= (slot >= last_slot) ? 2'h0 : 2'(slot + 2'h1);
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Per-channel filter state, cleared by reset or a change of filter settings.
  always_ff @(posedge clk) begin
    if (sys_rst || clear_all) begin
      win_sum <= '{default: '0};
      win_cnt <= '{default: '0};
      win_ptr <= '{default: '0};
      s1_sum <= '{default: '0};
      s1_cnt <= '{default: '0};
      s2_sum <= '{default: '0};
      s2_cnt <= '{default: '0};
      ain <= '{default: '0};
      valid <= '0;
    end else begin
      if (state == ST_ACC && !tc_mode && filt_depth != '0) begin
        win_sum[ch] <= win_next;
        win_ptr[ch] <= ptr_next;
        if (!win_full) begin
          win_cnt[ch] <= win_cnt_inc;
        end
      end
      if (state == ST_ACC && tc_mode && (tc_hi || tc_lo)) begin
        {s1_sum[ch], s1_cnt[ch], s2_sum[ch], s2_cnt[ch]} <= '0;
      end else if (state == ST_ACC && tc_mode) begin
        s1_sum[ch] <= (s1_cnt[ch] == TC_STAGE1_COUNT - 7'h01) ? '0 : s1_next;
        s1_cnt[ch] <= (s1_cnt[ch] == TC_STAGE1_COUNT - 7'h01) ? '0 : 7'(s1_cnt[ch] + 7'h01);
      end
      if (state == ST_DIV && div_cnt == '0 && stage == DS_TC1 && tc_depth != '0) begin
        s2_sum[ch] <= (s2_cnt[ch] == tc_depth - 7'h01) ? '0 : s2_next;
        s2_cnt[ch] <= (s2_cnt[ch] == tc_depth - 7'h01) ? '0 : 7'(s2_cnt[ch] + 7'h01);
      end
      if (pub_en) begin
        ain[ch] <= pub_word;
        valid[ch] <= pub_valid;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_start_after_tick;
    adc_start |-> $past(tick) && $past(state == ST_IDLE);
  endproperty
  a_start_after_tick: assert property (p_start_after_tick) else $error("start without tick");

  property p_single_start;
    adc_start |=> !adc_start [*8];
  endproperty
  a_single_start: assert property (p_single_start) else $error("double conversion start");

  property p_bypass_valid;
    (pub_en && !tc_mode && filt_depth == '0 && !clear_all) |=> valid[$past(ch)];
  endproperty
  a_bypass_valid: assert property (p_bypass_valid) else $error("bypass not valid");

  property p_invalid_zero;
    (!tc_mode && !valid[0]) |-> ain[0] == '0;
  endproperty
  a_invalid_zero: assert property (p_invalid_zero) else $error("invalid value not zero");

  property p_valid_full;
    (!tc_mode && valid[1] && filt_depth != '0) |-> win_cnt[1] == filt_depth;
  endproperty
  a_valid_full: assert property (p_valid_full) else $error("valid before window full");

  property p_dac_on_tick;
    $changed(dac_code_ch1) && !offline |-> $past(tick);
  endproperty
  a_dac_on_tick: assert property (p_dac_on_tick) else $error("output changed off tick");

  property p_offline_clear;
    offline |=> dac_code_ch1 == '0 && dac_code_ch2 == '0 && aout[0] == '0;
  endproperty
  a_offline_clear: assert property (p_offline_clear) else $error("offline not cleared");

  property p_hold;
    (tick && !prog_run && hold_en[0] && !offline) |=> $stable(dac_code_ch1);
  endproperty
  a_hold: assert property (p_hold) else $error("held output moved");

  property p_current_floor;
    (!tc_mode && range_420[1]) |-> $signed(ain[1]) >= $signed(CURRENT_VALUE_MIN);
  endproperty
  a_current_floor: assert property (p_current_floor) else $error("current value below floor");

  property p_tc_sentinel;
    (pub_en && tc_mode && pub_sent && !clear_all) |=>
      (ain[$past(ch)] == TC_SENTINEL_POS || ain[$past(ch)] == TC_SENTINEL_NEG);
  endproperty
  a_tc_sentinel: assert property (p_tc_sentinel) else $error("missing range sentinel");

  c_valid_rise: cover property (!tc_mode ##1 $rose(valid[0]));
  c_tc_publish: cover property (pub_en && tc_mode && stage == DS_TC2);
  c_hold_stop: cover property (tick && !prog_run && hold_en[0]);
endmodule

// file: test/host_model.sv
// Host controller model that scans the shared register window over the register port.
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk,
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata
);
  ////////////////////////////////////////////////////////////
  // The port idles with both strobes low.
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One-cycle write of output data or settings, once per program scan.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // One-cycle read; the data stand only in the following cycle.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

// file: test/testbench.sv
// Self-checking bench of the analog I/O sampling controller.
`timescale 1ns/1ps
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t ns: %s", $time, m); end end
module testbench;
  import analog_io_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        prog_run = 1'b1;
  logic        offline = 1'b0;
  logic        adc_done = 1'b0;
  logic [11:0] adc_code = 12'h000;
  logic [11:0] ofs = 12'h000;
  logic [11:0] code [3];
  logic [2:0]  pend = 3'h0;
  logic        alt = 1'b0;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd, adc_start, dac_load;
  logic [1:0]  adc_sel;
  logic [11:0] dac_code_ch1, dac_code_ch2;
  int          n_fail = 0;
  int          compares = 0;
  int          n_board = 0;

  ////////////////////////////////////////////////////////////
  // Clock of 25 ns.
  always #12.5 clk = ~clk;

  host_model host_inst (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  analog_io_ctrl #(.TICK_CYCLES(50)) analog_io_ctrl_inst (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .prog_run(prog_run), .offline(offline), .adc_start(adc_start),
    .adc_sel(adc_sel), .adc_done(adc_done), .adc_code(adc_code), .dac_load(dac_load),
    .dac_code_ch1(dac_code_ch1), .dac_code_ch2(dac_code_ch2));

  // Converter answers three cycles after a start; channel 1 may alternate by ofs.
  always @(posedge clk) begin
    pend     <= {pend[1:0], adc_start};
    adc_done <= pend[1];
    if (pend[1]) begin
      adc_code <= (adc_sel == 2'h0 && alt) ? code[0] + ofs : code[adc_sel];
      if (adc_sel == 2'h0) alt <= ~alt;
    end
    if (adc_start && adc_sel == 2'h2) n_board++;
  end

  ////////////////////////////////////////////////////////////
  // Waits for n output refreshes, which mark the scan ticks.
  task automatic ticks(input int n);
    repeat (n) @(posedge clk iff dac_load);
    #1;
  endtask

  // Reads a register and compares its low half.
  task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string m);
    logic [31:0] v;
    host_inst.rd(a, v);
    `CHK(v[15:0], e, m)
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #500000;
    n_fail++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    code[0] = 12'hFFF;
    code[1] = 12'h7FF;
    code[2] = 12'h123;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(REG_CONFIG, 16'h0000, "config reset");
    host_inst.wr(8'h40, 32'hFFFF);
    rdc(8'h40, 16'h0000, "unmapped read");
    ticks(4);
    rdc(REG_AIN_CH1, 16'h0FFF, "bypass full scale");
    rdc(REG_AIN_CH2, 16'h07FF, "bypass ch2");
    rdc(REG_VALID, 16'h0003, "valid word");
    // Depth four: alternating codes average to the floor of their mean.
    ofs = 12'h003;
    code[0] = 12'h100;
    host_inst.wr(REG_CONFIG, 32'h4);
    rdc(REG_VALID, 16'h0000, "valid cleared");
    rdc(REG_AIN_CH1, 16'h0000, "zero while filling");
    ticks(5);
    rdc(REG_VALID, 16'h0000, "valid before depth");
    ticks(6);
    rdc(REG_VALID, 16'h0003, "valid after depth");
    rdc(REG_AIN_CH1, 16'h0101, "running average");
    rdc(REG_AIN_CH2, 16'h07FF, "shared depth");
    // Channel 2 in the 4 to 20 mA range.
    ofs = 12'h000;
    code[1] = 12'h000;
    host_inst.wr(REG_CONFIG, 32'h0004_0000);
    ticks(4);
    rdc(REG_AIN_CH2, 16'hFC18, "current floor");
    rdc(REG_AIN_CH1, 16'h0100, "voltage range");
    code[1] = 12'h3E8;
    ticks(3);
    rdc(REG_AIN_CH2, 16'h00FA, "current scaling");
    // Output refresh, hold on channel 1, then offline.
    host_inst.wr(REG_AOUT_CH1, 32'hFFF);
    host_inst.wr(REG_AOUT_CH2, 32'h123);
    ticks(1);
    `CHK(dac_code_ch1, 12'hFFF, "dac full scale")
    `CHK(dac_code_ch2, 12'h123, "dac refresh")
    host_inst.wr(REG_CONFIG, 32'h000C_0000);
    @(posedge clk) prog_run <= 1'b0;
    host_inst.wr(REG_AOUT_CH1, 32'h555);
    ticks(2);
    `CHK(dac_code_ch1, 12'hFFF, "held output")
    `CHK(dac_code_ch2, 12'h000, "unheld output")
    @(posedge clk) prog_run <= 1'b1;
    ticks(1);
    `CHK(dac_code_ch1, 12'h555, "resumed output")
    @(posedge clk) offline <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK(dac_code_ch1, 12'h000, "offline clears")
    rdc(REG_AOUT_CH1, 16'h0000, "retained cleared");
    @(posedge clk) offline <= 1'b0;
    // Thermocouple mode with second-stage setting 1.
    code[0] = 12'h400;
    code[1] = 12'h500;
    host_inst.wr(REG_CONFIG, 32'h0001_0100);
    n_board = 0;
    ticks(57);
    `CHK(n_board, 19, "board slot count")
    rdc(REG_VALID, 16'h0000, "tc not yet valid");
    ticks(9);
    rdc(REG_VALID, 16'h0003, "tc valid");
    rdc(REG_AIN_CH1, 16'h0400, "tc average ch1");
    rdc(REG_AIN_CH2, 16'h0500, "tc average ch2");
    rdc(REG_BOARD_TEMP, 16'h0123, "board temperature");
    code[0] = 12'hFFF;
    ticks(4);
    rdc(REG_AIN_CH1, 16'h7FFF, "over range");
    // Second stage off: each first-stage average is published directly.
    code[0] = 12'h400;
    host_inst.wr(REG_CONFIG, 32'h0001_0000);
    ticks(66);
    rdc(REG_VALID, 16'h0003, "single stage valid");
    rdc(REG_AIN_CH1, 16'h0400, "single stage value");
    give_verdict();
  end
endmodule
